// *** src/mag_cfg.svh ***
// constants for the magnetometer bus front end and supply gating
// Overview of operation
// - A strap tied high selects single-supply operation with the regulator on, tied low selects dual supply.
// - With both supplies up in dual-supply operation every mode but off works and the regulator stays off.
// - With the analog supply down in dual-supply operation only idle works: no measurement, but bus and registers serve.
// - In single-supply operation with the analog supply up the regulator powers the logic and every mode but off works.
// - Reset loads every register with its default value.
// - Reset also returns the sequencer and bias control to their defaults.
// - The block is a bus slave only, selected by a 7-bit address, using the standard protocol.
// - Standard and fast bus rates work; the bench master clocks SCL at one eighth of the system clock, far above fast mode.
// - The clock and data inputs carry no spike filter, so short pulses reach the bus logic.
// - Master register accesses take precedence over internal measurement work.
// - In idle the block stays reachable and keeps registers but switches off converter, amplifier, sensor supply and bias.
`ifndef MAG_CFG_SVH
`define MAG_CFG_SVH
`define MAG_SLAVE_ADDR 7'h1e
`define MAG_REG_CFGA 8'h00
`define MAG_REG_CFGB 8'h01
`define MAG_REG_MODE 8'h02
`define MAG_REG_XMSB 8'h03
`define MAG_REG_XLSB 8'h04
`define MAG_REG_YMSB 8'h05
`define MAG_REG_YLSB 8'h06
`define MAG_REG_ZMSB 8'h07
`define MAG_REG_ZLSB 8'h08
`define MAG_REG_STAT 8'h09
`define MAG_REG_IDA 8'h0a
`define MAG_REG_IDB 8'h0b
`define MAG_REG_IDC 8'h0c
`define MAG_PTR_WRAP_AT 8'h09
`define MAG_PTR_WRAP_TO 8'h03
`define MAG_PTR_LAST 8'h0c
`define MAG_CFGA_RST 8'h10
`define MAG_CFGA_MASK 8'h1f
`define MAG_CFGB_RST 8'h00
`define MAG_MODE_RST 8'h01
`define MAG_MODE_MASK 8'h03
`define MAG_MD_CONT 2'h0
`define MAG_MD_SINGLE 2'h1
`define MAG_MD_IDLE 2'h2
`define MAG_MD_SLEEP 2'h3
`define MAG_STAT_RDY_BIT 0
// identification bytes: values are arbitrary
`define MAG_ID_A 8'h41
`define MAG_ID_B 8'h42
`define MAG_ID_C 8'h43
`endif

// *** src/mag_i2c_top.sv ***
// bus slave, register file and supply-dependent measurement gating
`timescale 1ns/1ps
`include "mag_cfg.svh"
module mag_i2c_top import mag_pkg::*; (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_O,
	input wire logic SUPPLY_SELECT_STRAP_I,
	input wire logic DIGITAL_SUPPLY_PIN_I,
	input wire logic ANALOG_SUPPLY_PIN_I,
	input wire logic MEAS_DONE_I,
	input wire logic [47:0] MEAS_DATA_I,
	output logic MEAS_START_O,
	output logic MEAS_ALLOWED_O,
	output logic REGULATOR_EN_O,
	output logic ANALOG_ON_O,
	output logic [1:0] BIAS_EN_O
);
	function automatic logic [7:0] ptr_advance(input logic [7:0] p);
		if (p == `MAG_PTR_WRAP_AT) begin
			return `MAG_PTR_WRAP_TO;
		end else if (p >= `MAG_PTR_LAST) begin
			return 8'h00;
		end
		return p + 8'h01;
	endfunction

	function automatic logic [7:0] reg_read(input logic [7:0] p, input logic [7:0] ca,
			input logic [7:0] cb, input logic [7:0] md, input logic [47:0] d,
			input logic [7:0] st);
		case (p)
			`MAG_REG_CFGA: return ca;
			`MAG_REG_CFGB: return cb;
			`MAG_REG_MODE: return md;
			`MAG_REG_XMSB: return d[47:40];
			`MAG_REG_XLSB: return d[39:32];
			`MAG_REG_YMSB: return d[31:24];
			`MAG_REG_YLSB: return d[23:16];
			`MAG_REG_ZMSB: return d[15:8];
			`MAG_REG_ZLSB: return d[7:0];
			`MAG_REG_STAT: return st;
			`MAG_REG_IDA: return `MAG_ID_A;
			`MAG_REG_IDB: return `MAG_ID_B;
			`MAG_REG_IDC: return `MAG_ID_C;
			default: return 8'h00;
		endcase
	endfunction

	// pin synchronisers; stage one feeds stage two only
	logic [4:0] sync1_reg, sync2_reg, sync1_next, sync2_next;
	logic scl_d_reg, sda_d_reg, scl_d_next, sda_d_next;
	always_comb begin
		sync1_next = {SCL_I, SDA_I, SUPPLY_SELECT_STRAP_I, DIGITAL_SUPPLY_PIN_I,
			ANALOG_SUPPLY_PIN_I};
		sync2_next = sync1_reg;
		scl_d_next = sync2_reg[4];
		sda_d_next = sync2_reg[3];
	end
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			sync1_reg <= 5'h18;
			sync2_reg <= 5'h18;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			scl_d_reg <= scl_d_next;
			sda_d_reg <= sda_d_next;
		end
	end

	logic scl_s, sda_s, strap_s, digital_supply_pin_s, analog_supply_pin_s;
	logic scl_rise, scl_fall, start_det, stop_det;
	assign scl_s = sync2_reg[4];
	assign sda_s = sync2_reg[3];
	assign strap_s = sync2_reg[2];
	assign digital_supply_pin_s = sync2_reg[1];
	assign analog_supply_pin_s = sync2_reg[0];
	// edges taken straight from the sampled pins, no spike suppression
	assign scl_rise = scl_s & ~scl_d_reg;
	assign scl_fall = ~scl_s & scl_d_reg;
	assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	mag_bus_st_t bus_st_reg, bus_st_next;
	mag_seq_st_t seq_reg, seq_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] shift_reg, shift_next, ptr_reg, ptr_next;
	logic rw_reg, rw_next, first_reg, first_next, oe_reg, oe_next;
	logic [7:0] cfga_reg, cfga_next, cfgb_reg, cfgb_next, mode_reg, mode_next;
	logic [7:0] stat_reg, stat_next;
	logic [47:0] data_reg, data_next, hold_reg, hold_next;
	logic [1:0] strap_cap_reg, strap_cap_next;
	logic ok_reg, ok_next, ana_reg, ana_next, strap_reg, strap_next;
	logic [1:0] bias_reg, bias_next;

	always_comb begin
		logic [7:0] tx;
		logic meas_ok;
		logic run_req;
		tx = 8'h00;
		meas_ok = 1'b0;
		run_req = 1'b0;
		bus_st_next = bus_st_reg;
		seq_next = seq_reg;
		cnt_next = cnt_reg;
		shift_next = shift_reg;
		ptr_next = ptr_reg;
		rw_next = rw_reg;
		first_next = first_reg;
		oe_next = oe_reg;
		cfga_next = cfga_reg;
		cfgb_next = cfgb_reg;
		mode_next = mode_reg;
		stat_next = stat_reg;
		data_next = data_reg;
		hold_next = hold_reg;
		// strap caught once, after the synchroniser has flushed its reset value
		strap_next = (strap_cap_reg == 2'h2) ? strap_s : strap_reg;
		strap_cap_next = (strap_cap_reg == 2'h3) ? 2'h3 : strap_cap_reg + 2'h1;
		// slave protocol engine; pure slave, never drives the clock line
		if (start_det) begin
			bus_st_next = MAG_ST_ADDR;
			cnt_next = 4'h0;
			oe_next = 1'b0;
		end else if (stop_det) begin
			bus_st_next = MAG_ST_IDLE;
			oe_next = 1'b0;
		end else begin
			case (bus_st_reg)
				MAG_ST_IDLE: begin
					oe_next = 1'b0;
				end
				MAG_ST_ADDR: begin
					if (scl_rise) begin
						shift_next = {shift_reg[6:0], sda_s};
						cnt_next = cnt_reg + 4'h1;
					end else if (scl_fall && cnt_reg == 4'h8) begin
						if (shift_reg[7:1] == `MAG_SLAVE_ADDR) begin
							bus_st_next = MAG_ST_AACK;
							oe_next = 1'b1;
							rw_next = shift_reg[0];
						end else begin
							bus_st_next = MAG_ST_IDLE;
						end
					end
				end
				MAG_ST_AACK, MAG_ST_TACK: begin
					if (bus_st_reg == MAG_ST_TACK && scl_rise && sda_s) begin
						bus_st_next = MAG_ST_IDLE;
					end else if (scl_fall) begin
						cnt_next = 4'h0;
						if (bus_st_reg == MAG_ST_TACK || rw_reg) begin
							tx = reg_read(ptr_reg, cfga_reg, cfgb_reg, mode_reg, data_reg, stat_reg);
							if (ptr_reg == `MAG_REG_ZLSB) begin
								stat_next[`MAG_STAT_RDY_BIT] = 1'b0;
							end
							shift_next = tx;
							ptr_next = ptr_advance(ptr_reg);
							oe_next = ~tx[7];
							bus_st_next = MAG_ST_TX;
						end else begin
							oe_next = 1'b0;
							first_next = 1'b1;
							bus_st_next = MAG_ST_RX;
						end
					end
				end
				MAG_ST_RX: begin
					if (scl_rise) begin
						shift_next = {shift_reg[6:0], sda_s};
						cnt_next = cnt_reg + 4'h1;
					end else if (scl_fall && cnt_reg == 4'h8) begin
						oe_next = 1'b1;
						bus_st_next = MAG_ST_RACK;
						first_next = 1'b0;
						if (first_reg) begin
							ptr_next = shift_reg;
						end else begin
							ptr_next = ptr_advance(ptr_reg);
							case (ptr_reg)
								`MAG_REG_CFGA: cfga_next = shift_reg & `MAG_CFGA_MASK;
								`MAG_REG_CFGB: cfgb_next = shift_reg;
								`MAG_REG_MODE: mode_next = shift_reg & `MAG_MODE_MASK;
								default: ;
							endcase
						end
					end
				end
				MAG_ST_RACK: begin
					if (scl_fall) begin
						oe_next = 1'b0;
						cnt_next = 4'h0;
						bus_st_next = MAG_ST_RX;
					end
				end
				MAG_ST_TX: begin
					if (scl_rise) begin
						cnt_next = cnt_reg + 4'h1;
					end else if (scl_fall) begin
						if (cnt_reg == 4'h8) begin
							oe_next = 1'b0;
							bus_st_next = MAG_ST_TACK;
						end else begin
							shift_next = {shift_reg[6:0], 1'b0};
							oe_next = ~shift_reg[6];
						end
					end
				end
				default: begin
					bus_st_next = MAG_ST_IDLE;
					oe_next = 1'b0;
				end
			endcase
		end
		// supply gating: single supply needs the analog rail, dual needs both
		meas_ok = strap_reg ? analog_supply_pin_s : (digital_supply_pin_s & analog_supply_pin_s);
		run_req = meas_ok && (mode_reg[1:0] == `MAG_MD_CONT ||
			mode_reg[1:0] == `MAG_MD_SINGLE);
		case (seq_reg)
			MAG_SQ_IDLE: begin
				if (run_req) begin
					seq_next = MAG_SQ_START;
				end
			end
			MAG_SQ_START: begin
				seq_next = MAG_SQ_WAIT;
			end
			MAG_SQ_WAIT: begin
				if (MEAS_DONE_I) begin
					hold_next = MEAS_DATA_I;
					seq_next = MAG_SQ_POST;
				end
			end
			MAG_SQ_POST: begin
				// results wait until the bus goes quiet so the master is never held up
				if (bus_st_reg == MAG_ST_IDLE) begin
					data_next = hold_reg;
					stat_next[`MAG_STAT_RDY_BIT] = 1'b1;
					if (mode_reg[1:0] == `MAG_MD_SINGLE) begin
						mode_next = {mode_reg[7:2], `MAG_MD_SLEEP};
					end
					seq_next = MAG_SQ_IDLE;
				end
			end
			default: seq_next = MAG_SQ_IDLE;
		endcase
		if (!run_req && seq_reg != MAG_SQ_POST) begin
			seq_next = MAG_SQ_IDLE;
		end
		ok_next = meas_ok;
		// idle or refused measurement keeps the analog path dark
		ana_next = seq_next != MAG_SQ_IDLE;
		bias_next = ana_next ? cfga_reg[1:0] : 2'h0;
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			bus_st_reg <= MAG_ST_IDLE;
			seq_reg <= MAG_SQ_IDLE;
			cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			ptr_reg <= 8'h00;
			rw_reg <= 1'b0;
			first_reg <= 1'b0;
			oe_reg <= 1'b0;
			cfga_reg <= `MAG_CFGA_RST;
			cfgb_reg <= `MAG_CFGB_RST;
			mode_reg <= `MAG_MODE_RST;
			stat_reg <= 8'h00;
			data_reg <= 48'h0;
			hold_reg <= 48'h0;
			strap_reg <= 1'b0;
			strap_cap_reg <= 2'h0;
			ok_reg <= 1'b0;
			ana_reg <= 1'b0;
			bias_reg <= 2'h0;
		end else begin
			bus_st_reg <= bus_st_next;
			seq_reg <= seq_next;
			cnt_reg <= cnt_next;
			shift_reg <= shift_next;
			ptr_reg <= ptr_next;
			rw_reg <= rw_next;
			first_reg <= first_next;
			oe_reg <= oe_next;
			cfga_reg <= cfga_next;
			cfgb_reg <= cfgb_next;
			mode_reg <= mode_next;
			stat_reg <= stat_next;
			data_reg <= data_next;
			hold_reg <= hold_next;
			strap_reg <= strap_next;
			strap_cap_reg <= strap_cap_next;
			ok_reg <= ok_next;
			ana_reg <= ana_next;
			bias_reg <= bias_next;
		end
	end

	// open drain: only ever pulls low
	assign SDA_O = 1'b0;
	assign SDA_OE_O = oe_reg;
	assign MEAS_START_O = seq_reg == MAG_SQ_START;
	assign MEAS_ALLOWED_O = ok_reg;
	assign REGULATOR_EN_O = strap_reg;
	assign ANALOG_ON_O = ana_reg;
	assign BIAS_EN_O = bias_reg;
endmodule

// *** src/mag_pkg.sv ***
// types for the magnetometer bus front end
package mag_pkg;
	typedef enum logic [6:0] {
		MAG_ST_IDLE = 7'h01,
		MAG_ST_ADDR = 7'h02,
		MAG_ST_AACK = 7'h04,
		MAG_ST_RX = 7'h08,
		MAG_ST_RACK = 7'h10,
		MAG_ST_TX = 7'h20,
		MAG_ST_TACK = 7'h40
	} mag_bus_st_t;
	typedef enum logic [3:0] {
		MAG_SQ_IDLE = 4'h1,
		MAG_SQ_START = 4'h2,
		MAG_SQ_WAIT = 4'h4,
		MAG_SQ_POST = 4'h8
	} mag_seq_st_t;
endpackage

// *** verif/mag_i2c_chk.sv ***
// port assertions for the magnetometer bus front end
`timescale 1ns/1ps
module mag_i2c_chk (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic SCL_I,
	input wire logic SDA_O,
	input wire logic SDA_OE_O,
	input wire logic SUPPLY_SELECT_STRAP_I,
	input wire logic ANALOG_SUPPLY_PIN_I,
	input wire logic MEAS_START_O,
	input wire logic MEAS_ALLOWED_O,
	input wire logic REGULATOR_EN_O,
	input wire logic ANALOG_ON_O,
	input wire logic [1:0] BIAS_EN_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	open_drain_a: assert property (SDA_O == 1'b0)
		else $error("sda data value not low");
	oe_clock_low_a: assert property ($changed(SDA_OE_O) |-> !$past(SCL_I, 2))
		else $error("sda drive moved while clock high");
	rst_quiet_a: assert property ($fell(RST_I) |-> !SDA_OE_O && !MEAS_START_O && !ANALOG_ON_O
		&& BIAS_EN_O == 2'h0)
		else $error("outputs not at defaults after reset");
	strap_reg_a: assert property ($fell(RST_I) |-> ##3 REGULATOR_EN_O == SUPPLY_SELECT_STRAP_I)
		else $error("regulator enable differs from strap");
	start_gate_a: assert property (MEAS_START_O |-> MEAS_ALLOWED_O)
		else $error("start without supply");
	start_pulse_a: assert property (MEAS_START_O |=> !MEAS_START_O)
		else $error("start longer than one cycle");
	start_power_a: assert property (MEAS_START_O |-> ##[0:1] ANALOG_ON_O)
		else $error("analog not on after start");
	bias_off_a: assert property (!ANALOG_ON_O |-> BIAS_EN_O == 2'h0)
		else $error("bias on while analog off");
	no_supply_a: assert property (!ANALOG_SUPPLY_PIN_I [*8] |-> !MEAS_ALLOWED_O && !ANALOG_ON_O)
		else $error("measurement allowed without analog supply");
endmodule
bind mag_i2c_top mag_i2c_chk chk (.CLK_I, .RST_I, .SCL_I, .SDA_O, .SDA_OE_O,
	.SUPPLY_SELECT_STRAP_I, .ANALOG_SUPPLY_PIN_I, .MEAS_START_O, .MEAS_ALLOWED_O,
	.REGULATOR_EN_O, .ANALOG_ON_O, .BIAS_EN_O);

// *** verif/mag_i2c_master.sv ***
// bus master model driving clock and data of the block
`timescale 1ns/1ps
module mag_i2c_master (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	// clock stands high between frames; plain traffic only, no high-speed code
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// data moves only in mid-low so the slave never sees a false start or stop
	task automatic seg(input logic low);
		scl_o <= 1'b0;
		hold(2);
		sda_low_o <= low;
		hold(2);
		scl_o <= 1'b1;
		hold(4);
	endtask
	task automatic start();
		seg(1'b0);
		sda_low_o <= 1'b1;
		hold(4);
	endtask
	task automatic stop();
		seg(1'b1);
		sda_low_o <= 1'b0;
		hold(4);
	endtask
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--) begin
			seg(!d[i]);
			q[i] = sda_i;
		end
		seg(!last);
		ack = !sda_i;
	endtask
endmodule

// *** verif/mag_i2c_top_tb_top.sv ***
// self-checking bench for the magnetometer bus front end
`timescale 1ns/1ps
`include "mag_cfg.svh"
module mag_i2c_top_tb_top;
	logic clk = 1'b0, rst = 1'b1, strap = 1'b0, analog_supply_pin = 1'b1, done = 1'b0, digital_supply_pin = 1'b1;
	logic [47:0] mdata = 48'h0;
	wire scl, sda_low, sda_oe, sda_o, meas_go, allowed, reg_en, ana_on;
	wire [1:0] bias;
	// pull-up: wire is low while either party pulls
	wire sda = !(sda_low || sda_oe);
	int n_fail = 0, check_count = 0, n_start = 0;
	mag_i2c_top uut (.CLK_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
		.SDA_OE_O(sda_oe), .SUPPLY_SELECT_STRAP_I(strap), .DIGITAL_SUPPLY_PIN_I(digital_supply_pin),
		.ANALOG_SUPPLY_PIN_I(analog_supply_pin), .MEAS_DONE_I(done), .MEAS_DATA_I(mdata),
		.MEAS_START_O(meas_go), .MEAS_ALLOWED_O(allowed), .REGULATOR_EN_O(reg_en),
		.ANALOG_ON_O(ana_on), .BIAS_EN_O(bias));
	mag_i2c_master m (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
	initial forever #10 clk = ~clk;
	always @(posedge clk) if (meas_go === 1'b1) n_start <= n_start + 1;
	task automatic check(input string what, input logic [47:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic do_reset(input logic s);
		strap <= s;
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] p, v);
		logic [7:0] q;
		logic a;
		m.start();
		m.xfer({`MAG_SLAVE_ADDR, 1'b0}, 1'b1, q, a);
		m.xfer(p, 1'b1, q, a);
		m.xfer(v, 1'b1, q, a);
		check("write ack", a, 1'b1);
		m.stop();
	endtask
	task automatic rd(input logic [7:0] p, input int n, output logic [47:0] r);
		logic [7:0] q;
		logic a;
		r = 48'h0;
		m.start();
		m.xfer({`MAG_SLAVE_ADDR, 1'b0}, 1'b1, q, a);
		m.xfer(p, 1'b1, q, a);
		m.start();
		m.xfer({`MAG_SLAVE_ADDR, 1'b1}, 1'b1, q, a);
		check("read ack", a, 1'b1);
		for (int i = 1; i <= n; i++) begin
			m.xfer(8'hff, i == n, q, a);
			r = {r[39:0], q};
		end
		m.stop();
	endtask
	task automatic t_defaults();
		logic [47:0] r;
		check("regulator", reg_en, 1'b0);
		check("allowed", allowed, 1'b1);
		rd(`MAG_REG_CFGA, 3, r);
		check("defaults", r, {`MAG_CFGA_RST, `MAG_CFGB_RST, `MAG_MODE_RST});
	endtask
	// result arrives mid-transaction: the bus keeps the old view until the master's closing nack
	task automatic t_priority();
		logic [47:0] r;
		mdata <= 48'h123456789abc;
		fork
			rd(`MAG_REG_STAT, 1, r);
			begin
				repeat (100) @(posedge clk);
				done <= 1'b1;
				@(posedge clk);
				done <= 1'b0;
			end
		join
		check("status during bus", r, 48'h0);
		rd(`MAG_REG_STAT, 1, r);
		check("status after", r, 48'h1);
		rd(`MAG_REG_XMSB, 6, r);
		check("data", r, 48'h123456789abc);
	endtask
	task automatic t_wrong();
		logic [7:0] q;
		logic a;
		m.start();
		m.xfer({7'h1f, 1'b0}, 1'b1, q, a);
		check("foreign ack", a, 1'b0);
		m.stop();
	endtask
	task automatic t_modes();
		logic [47:0] r;
		int n;
		wr(`MAG_REG_MODE, 8'h02);
		wr(`MAG_REG_CFGA, 8'h11);
		check("idle analog", ana_on, 1'b0);
		n = n_start;
		wr(`MAG_REG_MODE, 8'h00);
		repeat (10) @(posedge clk);
		check("cont start", n_start > n, 1'b1);
		check("bias", bias, 2'h1);
		wr(`MAG_REG_MODE, 8'h02);
		repeat (10) @(posedge clk);
		check("abort analog", ana_on, 1'b0);
		rd(`MAG_REG_CFGA, 1, r);
		check("idle keeps", r, 48'h11);
	endtask
	task automatic t_no_analog();
		logic [47:0] r;
		int n;
		analog_supply_pin <= 1'b0;
		repeat (10) @(posedge clk);
		check("allowed", allowed, 1'b0);
		n = n_start;
		wr(`MAG_REG_MODE, 8'h00);
		repeat (20) @(posedge clk);
		check("no start", n_start == n, 1'b1);
		rd(`MAG_REG_CFGA, 1, r);
		check("reg access", r, 48'h11);
		analog_supply_pin <= 1'b1;
	endtask
	task automatic t_single();
		logic [47:0] r;
		int n;
		n = n_start;
		do_reset(1'b1);
		check("regulator", reg_en, 1'b1);
		check("allowed", allowed, 1'b1);
		check("single start", n_start > n, 1'b1);
		rd(`MAG_REG_CFGA, 3, r);
		check("defaults", r, {`MAG_CFGA_RST, `MAG_CFGB_RST, `MAG_MODE_RST});
		// regulated logic must not depend on the digital pin
		digital_supply_pin <= 1'b0;
		analog_supply_pin <= 1'b0;
		repeat (10) @(posedge clk);
		check("single no analog", allowed, 1'b0);
		analog_supply_pin <= 1'b1;
		repeat (10) @(posedge clk);
		check("single regulated", allowed, 1'b1);
	endtask
	initial begin
		do_reset(1'b0);
		t_defaults();
		t_priority();
		t_wrong();
		t_modes();
		t_no_analog();
		t_single();
		conclude();
	end
	initial begin
		repeat (30000) @(posedge clk);
		n_fail++;
		conclude();
	end
endmodule
